// ==== src/mgmt_pkg.sv ====
// constants shared by the management-mode entry/resume control and its save-area port
// assumes a 32-bit byte-addressed path to management ram
package mgmt_pkg;

   // ********************************************************************
   // state-save field offsets, relative to the management ram base
   // ********************************************************************
   localparam logic [15:0] OFS_BASE_FIELD = 16'h7ef8;
   localparam logic [15:0] OFS_CAP_ID = 16'h7efc;
   localparam logic [15:0] OFS_IO_RESTART = 16'h7f00;
   localparam logic [15:0] OFS_HALT_RESTART = 16'h7f02;

   // ********************************************************************
   // field layouts and values
   // ********************************************************************
   localparam int HALT_FLAG_BIT = 0;
   // halt flag position inside the word read at the i/o restart offset
   localparam int HALT_WORD_BIT = (OFS_HALT_RESTART - OFS_IO_RESTART) * 8 + HALT_FLAG_BIT;
   localparam logic [7:0] IO_REEXEC = 8'hff;
   localparam logic [15:0] IO_NO_REEXEC = 16'h0000;
   localparam int CAP_IO_RESTART_BIT = 16;
   localparam int CAP_RELOC_BIT = 17;
   // base architecture version; value is arbitrary
   localparam logic [15:0] ARCH_VERSION = 16'h0001;
   localparam logic [15:0] CAP_EXT = 16'h0003;
   localparam int SEG_SHIFT = 4;

   // ********************************************************************
   // reset and entry values
   // ********************************************************************
   localparam logic [31:0] BASE_RESET = 32'h0003_0000;
   localparam logic [31:0] ENTRY_IP = 32'h0000_8000;

   typedef enum {
      ST_RUN, ST_HALTED, ST_HALT_FETCH, ST_HALT_BUS, ST_WR_ID, ST_WR_FLAGS,
      ST_MGMT, ST_MGMT_HALT, ST_RD_BASE, ST_RD_FLAGS
   } ctl_state_type;

endpackage

// ==== src/save_if.sv ====
// request/answer path from the control fsm to the save-area port
// assumes both ends sit on mclk_in
interface save_if;
   logic req;
   logic we;
   logic [15:0] offset;
   logic [31:0] wdata;
   logic [31:0] base;
   logic [31:0] rdata;
   logic done;
   modport ctrl (output req, output we, output offset, output wdata, output base,
                 input rdata, input done);
   modport port (input req, input we, input offset, input wdata, input base,
                 output rdata, output done);
endinterface

// ==== src/save_area_port.sv ====
// one-word-at-a-time access to the state-save area in management ram
// assumes the memory answers each request with a one-cycle mem_ack_in
module save_area_port
   import mgmt_pkg::*;
(
   input wire logic mclk_in,
   input wire logic resetn_in,
   save_if.port sv,
   output logic mem_req_out,
   output logic mem_we_out,
   output logic [31:0] mem_addr_out,
   output logic [31:0] mem_wdata_out,
   input wire logic [31:0] mem_rdata_in,
   input wire logic mem_ack_in
);

   logic next_req, next_we, next_done;
   logic [31:0] next_addr, next_wdata, next_rdata;

   // issue when idle; done blocks a second issue in the cycle the fsm moves on
   always_comb begin
      next_req = mem_req_out;
      next_we = mem_we_out;
      next_addr = mem_addr_out;
      next_wdata = mem_wdata_out;
      next_rdata = sv.rdata;
      next_done = 1'b0;
      if (!mem_req_out && sv.req && !sv.done) begin
         next_req = 1'b1;
         next_we = sv.we;
         next_addr = sv.base + {16'h0000, sv.offset};
         next_wdata = sv.wdata;
      end else if (mem_req_out && mem_ack_in) begin
         next_req = 1'b0;
         next_done = 1'b1;
         next_rdata = mem_rdata_in;
      end
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mem_req_out <= 1'b0;
         mem_we_out <= 1'b0;
         mem_addr_out <= 32'h0000_0000;
         mem_wdata_out <= 32'h0000_0000;
         sv.rdata <= 32'h0000_0000;
         sv.done <= 1'b0;
      end else begin
         mem_req_out <= next_req;
         mem_we_out <= next_we;
         mem_addr_out <= next_addr;
         mem_wdata_out <= next_wdata;
         sv.rdata <= next_rdata;
         sv.done <= next_done;
      end
   end

endmodule

// ==== src/mgmt_resume_control.sv ====
// management-mode entry and resume control: save-area fields, base register, return point
// assumes the core reports halts, trapped i/o and the resume instruction as one-cycle pulses,
// and that all pins are synchronous to mclk_in

module mgmt_resume_control
   import mgmt_pkg::*;
(
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic soft_init_in,
   input wire logic management_interrupt_pin_n_in,
   input wire logic lic_msg_valid_in,
   input wire logic lic_msg_mgmt_in,
   input wire logic halt_exec_in,
   input wire logic io_trap_in,
   input wire logic [31:0] instr_ip_in,
   input wire logic [31:0] next_ip_in,
   input wire logic resume_in,
   input wire logic intr_in,
   input wire logic halt_cached_in,
   input wire logic seg_load_in,
   input wire logic [15:0] seg_sel_in,
   output logic management_mode_out,
   output logic halted_out,
   output logic ip_load_out,
   output logic [31:0] ip_value_out,
   output logic [31:0] cs_base_out,
   output logic io_reexec_out,
   output logic halt_fetch_out,
   output logic halt_bus_out,
   output logic [31:0] seg_base_out,
   output logic [31:0] mgmt_ram_base_out,
   output logic mem_req_out,
   output logic mem_we_out,
   output logic [31:0] mem_addr_out,
   output logic [31:0] mem_wdata_out,
   input wire logic [31:0] mem_rdata_in,
   input wire logic mem_ack_in
);

   // ********************************************************************
   // helpers
   // ********************************************************************

   // real-mode style base: no more than 20 address bits reachable
   function automatic logic [31:0] seg_base(input logic [15:0] sel);
      seg_base = {12'h000, sel, 4'h0};
   endfunction

   // capability word written on each entry
   function automatic logic [31:0] cap_word();
      logic [31:0] w;
      w = {CAP_EXT, ARCH_VERSION};
      w[CAP_IO_RESTART_BIT] = 1'b1;
      w[CAP_RELOC_BIT] = 1'b1;
      cap_word = w;
   endfunction

   save_if sv ();

   save_area_port u_port (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .sv(sv),
      .mem_req_out(mem_req_out),
      .mem_we_out(mem_we_out),
      .mem_addr_out(mem_addr_out),
      .mem_wdata_out(mem_wdata_out),
      .mem_rdata_in(mem_rdata_in),
      .mem_ack_in(mem_ack_in)
   );

   // ********************************************************************
   // management interrupt intake
   // ********************************************************************

   logic pin_prev, next_pin_prev;
   logic pending, next_pending;
   logic take;
   logic raise;

   // the pin is a level; only its falling edge raises a request, so a held
   // pin does not re-enter straight after resume
   assign raise = (pin_prev && !management_interrupt_pin_n_in)
                  || (lic_msg_valid_in && lic_msg_mgmt_in);

   // a request that lands with the take still wins
   always_comb begin
      next_pin_prev = management_interrupt_pin_n_in;
      next_pending = raise | (pending & ~take);
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pin_prev <= 1'b1;
         pending <= 1'b0;
      end else begin
         pin_prev <= next_pin_prev;
         pending <= next_pending;
      end
   end

   // ********************************************************************
   // control state machine
   // ********************************************************************

   ctl_state_type state, next_state;
   logic [31:0] base, next_base;
   logic [31:0] base_read, next_base_read;
   logic [31:0] trap_ip, next_trap_ip;
   logic [31:0] ret_ip, next_ret_ip;
   logic entry_halted, next_entry_halted;
   logic next_mode, next_halted, next_ip_load, next_io_reexec;
   logic next_halt_fetch, next_halt_bus;
   logic [31:0] next_ip_value, next_cs_base;
   logic entry_ok;
   logic io_hit, halt_hit;

   // entry is only taken between instructions or from a halt outside the mode
   assign entry_ok = pending && (state == ST_RUN || state == ST_HALTED);
   assign take = entry_ok;

   // save-area request drive
   always_comb begin
      sv.req = 1'b0;
      sv.we = 1'b0;
      sv.offset = OFS_CAP_ID;
      sv.wdata = 32'h0000_0000;
      sv.base = base;
      case (state)
         ST_WR_ID: begin
            sv.req = 1'b1;
            sv.we = 1'b1;
            sv.offset = OFS_CAP_ID;
            sv.wdata = cap_word();
         end
         ST_WR_FLAGS: begin
            sv.req = 1'b1;
            sv.we = 1'b1;
            sv.offset = OFS_IO_RESTART;
            sv.wdata = {16'h0000, IO_NO_REEXEC};
            sv.wdata[HALT_WORD_BIT] = entry_halted;
         end
         ST_RD_BASE: begin
            sv.req = 1'b1;
            sv.offset = OFS_BASE_FIELD;
         end
         ST_RD_FLAGS: begin
            sv.req = 1'b1;
            sv.offset = OFS_IO_RESTART;
         end
         default: begin
            sv.req = 1'b0;
         end
      endcase
   end

   // resume decode on the flags word just read
   assign io_hit = (sv.rdata[7:0] == IO_REEXEC);
   // a flag set by the handler after a non-halted entry is ignored
   assign halt_hit = entry_halted && sv.rdata[HALT_WORD_BIT];

   // next-state and next-output computation
   always_comb begin
      next_state = state;
      next_base = base;
      next_base_read = base_read;
      next_trap_ip = trap_ip;
      next_ret_ip = ret_ip;
      next_entry_halted = entry_halted;
      next_mode = management_mode_out;
      next_halted = halted_out;
      next_ip_load = 1'b0;
      next_ip_value = ip_value_out;
      next_cs_base = cs_base_out;
      next_io_reexec = 1'b0;
      next_halt_fetch = 1'b0;
      next_halt_bus = 1'b0;
      case (state)
         ST_RUN: begin
            if (entry_ok) begin
               // trapped i/o keeps its own address for a possible re-execute
               next_trap_ip = instr_ip_in;
               next_ret_ip = io_trap_in ? next_ip_in : instr_ip_in;
               next_entry_halted = 1'b0;
               next_mode = 1'b1;
               next_state = ST_WR_ID;
            end else if (halt_exec_in) begin
               next_trap_ip = instr_ip_in;
               next_ret_ip = next_ip_in;
               next_halted = 1'b1;
               next_halt_bus = 1'b1;
               next_state = ST_HALTED;
            end else if (soft_init_in) begin
               next_state = ST_RUN;
            end
         end
         ST_HALTED: begin
            if (entry_ok) begin
               next_entry_halted = 1'b1;
               next_halted = 1'b0;
               next_mode = 1'b1;
               next_state = ST_WR_ID;
            end else if (intr_in || soft_init_in) begin
               // base stays as it is across a soft init
               next_halted = 1'b0;
               next_state = ST_RUN;
            end
         end
         ST_WR_ID: begin
            if (sv.done) begin
               next_state = ST_WR_FLAGS;
            end
         end
         ST_WR_FLAGS: begin
            if (sv.done) begin
               // handler starts at the fixed offset inside the current base
               next_ip_load = 1'b1;
               next_ip_value = ENTRY_IP;
               next_cs_base = base;
               next_state = ST_MGMT;
            end
         end
         ST_MGMT: begin
            // further management interrupts stay pending: no re-entry
            if (resume_in) begin
               next_state = ST_RD_BASE;
            end else if (halt_exec_in) begin
               next_halted = 1'b1;
               next_halt_bus = 1'b1;
               next_state = ST_MGMT_HALT;
            end else if (seg_load_in) begin
               next_cs_base = cs_base_out;
            end
         end
         ST_MGMT_HALT: begin
            // soft init and management interrupts cannot wake this halt
            if (intr_in) begin
               next_halted = 1'b0;
               next_state = ST_MGMT;
            end
         end
         ST_RD_BASE: begin
            if (sv.done) begin
               // held aside so the flags read still uses the old base
               next_base_read = sv.rdata;
               next_state = ST_RD_FLAGS;
            end
         end
         ST_RD_FLAGS: begin
            if (sv.done) begin
               next_base = base_read;
               next_mode = 1'b0;
               next_ip_load = 1'b1;
               if (io_hit) begin
                  next_ip_value = trap_ip;
                  next_io_reexec = 1'b1;
                  next_state = ST_RUN;
               end else if (halt_hit) begin
                  next_ip_value = trap_ip;
                  next_state = ST_HALT_FETCH;
               end else begin
                  next_ip_value = ret_ip;
                  next_state = ST_RUN;
               end
            end
         end
         ST_HALT_FETCH: begin
            // the halt opcode is read again unless the cache still holds it
            next_halt_fetch = !halt_cached_in;
            next_state = ST_HALT_BUS;
         end
         ST_HALT_BUS: begin
            // one more halt transaction for the same instruction
            next_halt_bus = 1'b1;
            next_halted = 1'b1;
            next_state = ST_HALTED;
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   // base only takes its reset value from the hardware reset
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state <= ST_RUN;
         base <= BASE_RESET;
         base_read <= BASE_RESET;
         trap_ip <= 32'h0000_0000;
         ret_ip <= 32'h0000_0000;
         entry_halted <= 1'b0;
         management_mode_out <= 1'b0;
         halted_out <= 1'b0;
         ip_load_out <= 1'b0;
         ip_value_out <= 32'h0000_0000;
         cs_base_out <= 32'h0000_0000;
         io_reexec_out <= 1'b0;
         halt_fetch_out <= 1'b0;
         halt_bus_out <= 1'b0;
         mgmt_ram_base_out <= BASE_RESET;
      end else begin
         state <= next_state;
         base <= next_base;
         base_read <= next_base_read;
         trap_ip <= next_trap_ip;
         ret_ip <= next_ret_ip;
         entry_halted <= next_entry_halted;
         management_mode_out <= next_mode;
         halted_out <= next_halted;
         ip_load_out <= next_ip_load;
         ip_value_out <= next_ip_value;
         cs_base_out <= next_cs_base;
         io_reexec_out <= next_io_reexec;
         halt_fetch_out <= next_halt_fetch;
         halt_bus_out <= next_halt_bus;
         mgmt_ram_base_out <= next_base;
      end
   end

   // ********************************************************************
   // segment base formation in management mode
   // ********************************************************************

   logic [31:0] next_seg_base;

   // selector loads outside the mode belong to other logic
   always_comb begin
      next_seg_base = seg_base_out;
      if (seg_load_in && management_mode_out) begin
         next_seg_base = seg_base(seg_sel_in);
      end
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         seg_base_out <= 32'h0000_0000;
      end else begin
         seg_base_out <= next_seg_base;
      end
   end

endmodule

// ==== bench/mgmt_resume_control_checker.sv ====
// concurrent checks on the management-mode entry/resume control, top-level pins only
// assumes every pin is synchronous to mclk_in and the save-area bus moves one word at a time
module mgmt_resume_control_checker
   import mgmt_pkg::*;
(
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic management_interrupt_pin_n_in,
   input wire logic lic_msg_valid_in,
   input wire logic lic_msg_mgmt_in,
   input wire logic intr_in,
   input wire logic halt_cached_in,
   input wire logic seg_load_in,
   input wire logic [15:0] seg_sel_in,
   input wire logic management_mode_out,
   input wire logic halted_out,
   input wire logic ip_load_out,
   input wire logic [31:0] ip_value_out,
   input wire logic [31:0] cs_base_out,
   input wire logic io_reexec_out,
   input wire logic halt_fetch_out,
   input wire logic halt_bus_out,
   input wire logic [31:0] seg_base_out,
   input wire logic [31:0] mgmt_ram_base_out,
   input wire logic mem_req_out,
   input wire logic mem_we_out,
   input wire logic [31:0] mem_addr_out,
   input wire logic [31:0] mem_wdata_out,
   input wire logic [31:0] mem_rdata_in,
   input wire logic mem_ack_in
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking chk_clk @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);

   // ********************************************************************
   // helper state
   // ********************************************************************
   logic mode_q, halted_q, entry_halted, rehalt;
   logic [31:0] rd_base, rd_flags, io_addr, base_addr;

   // field addresses follow the live base, so relocation shows up here at once
   assign io_addr = mgmt_ram_base_out + {16'h0000, OFS_IO_RESTART};
   assign base_addr = mgmt_ram_base_out + {16'h0000, OFS_BASE_FIELD};
   assign rehalt = (rd_flags[7:0] != IO_REEXEC) && rd_flags[HALT_WORD_BIT] && entry_halted;

   // halt state at entry and the two words read back on resume
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mode_q <= 1'b0;
         halted_q <= 1'b0;
         entry_halted <= 1'b0;
         rd_base <= BASE_RESET;
         rd_flags <= 32'h0000_0000;
      end else begin
         mode_q <= management_mode_out;
         halted_q <= halted_out;
         if (management_mode_out && !mode_q) begin
            entry_halted <= halted_q;
         end
         if (mem_req_out && !mem_we_out && mem_ack_in && mem_addr_out == base_addr) begin
            rd_base <= mem_rdata_in;
         end
         if (mem_req_out && !mem_we_out && mem_ack_in && mem_addr_out == io_addr) begin
            rd_flags <= mem_rdata_in;
         end
      end
   end

   // ********************************************************************
   // assertions
   // ********************************************************************
   a_entry_cap_write: assert property ($rose(management_mode_out) |=> mem_req_out && mem_we_out
      && mem_addr_out == mgmt_ram_base_out + {16'h0000, OFS_CAP_ID} && mem_wdata_out[15:0] == ARCH_VERSION
      && mem_wdata_out[CAP_IO_RESTART_BIT] && mem_wdata_out[CAP_RELOC_BIT]) else $error("capability write wrong");
   a_io_field_clear: assert property (mem_req_out && mem_we_out && mem_addr_out == io_addr |->
      mem_wdata_out[15:0] == IO_NO_REEXEC && mem_wdata_out[HALT_WORD_BIT] == entry_halted)
      else $error("restart word written wrong");
   a_entry_ip_base: assert property (ip_load_out && management_mode_out |->
      ip_value_out == ENTRY_IP && cs_base_out == mgmt_ram_base_out) else $error("entry point wrong");
   a_base_after_reset: assert property ($rose(resetn_in) |-> mgmt_ram_base_out == BASE_RESET)
      else $error("base not at reset value");
   a_base_reload: assert property ($fell(management_mode_out) |-> ##[0:2] mgmt_ram_base_out == rd_base)
      else $error("base not reloaded");
   a_io_reexec_pick: assert property ($fell(management_mode_out) |-> ip_load_out
      && io_reexec_out == (rd_flags[7:0] == IO_REEXEC)) else $error("return point wrong");
   a_halt_restart: assert property ($fell(management_mode_out) && rehalt |=>
      halt_fetch_out == !$past(halt_cached_in) ##1 halt_bus_out ##1 halted_out) else $error("halt not restarted");
   a_mgmt_halt_hold: assert property (management_mode_out && halted_out && !intr_in |=> halted_out)
      else $error("left halt without interrupt");
   a_seg_base_shift: assert property (seg_load_in && management_mode_out |=>
      seg_base_out == {12'h000, $past(seg_sel_in), 4'h0}) else $error("segment base wrong");
   a_intake_entry: assert property (($fell(management_interrupt_pin_n_in) || lic_msg_valid_in
      && lic_msg_mgmt_in) && !management_mode_out |-> ##[1:3] management_mode_out) else $error("interrupt not taken");

   c_halt_restart: cover property ($fell(management_mode_out) && rehalt);
   c_io_reexec: cover property (io_reexec_out);
   c_mgmt_halt_wake: cover property (management_mode_out && halted_out && intr_in);
endmodule

bind mgmt_resume_control mgmt_resume_control_checker chk (.*);

// ==== bench/mgmt_ram_model.sv ====
// management ram model answering the save-area bus one word at a time
// assumes a request holds until acknowledged; delay is set by the bench
module mgmt_ram_model (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic req_in,
   input wire logic we_in,
   input wire logic [31:0] addr_in,
   input wire logic [31:0] wdata_in,
   output logic [31:0] rdata_out,
   output logic ack_out
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [31:0] words [logic [31:0]];
   int delay = 0;
   int wait_cnt;

   // ack after delay idle cycles; read data toggles outside a read ack cycle so stale data never looks valid
   always @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wait_cnt = 0;
         ack_out <= 1'b0;
         rdata_out <= 32'h0000_0000;
      end else begin
         ack_out <= 1'b0;
         rdata_out <= ~rdata_out;
         if (req_in && !ack_out) begin
            if (wait_cnt < delay) begin
               wait_cnt++;
            end else begin
               wait_cnt = 0;
               ack_out <= 1'b1;
               if (we_in) begin
                  words[addr_in] = wdata_in;
               end else begin
                  rdata_out <= words.exists(addr_in) ? words[addr_in] : 32'hffff_ffff;
               end
            end
         end
      end
   end
endmodule

// ==== bench/mgmt_resume_control_tb_top.sv ====
// self-checking bench for the management-mode entry/resume control
// assumes the ram model holds the save area and the bench plays the handler
module mgmt_resume_control_tb_top
   import mgmt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   localparam logic [7:0] P_PIN = 8'h80, P_LIC = 8'h60, P_LICX = 8'h20, P_SOFT = 8'h10;
   localparam logic [7:0] P_HALT = 8'h08, P_RES = 8'h04, P_INTR = 8'h02, P_SEG = 8'h01;

   logic mclk_in, resetn_in, soft_init_in, management_interrupt_pin_n_in, lic_msg_valid_in, lic_msg_mgmt_in;
   logic halt_exec_in, io_trap_in, resume_in, intr_in, halt_cached_in, seg_load_in, mem_ack_in;
   logic management_mode_out, halted_out, ip_load_out, io_reexec_out, halt_fetch_out, halt_bus_out;
   logic mem_req_out, mem_we_out, trap_now, cached_now;
   logic [7:0] strobes;
   logic [15:0] seg_sel_in, sel_now;
   logic [31:0] instr_ip_in, next_ip_in, ip_value_out, cs_base_out, seg_base_out, mgmt_ram_base_out;
   logic [31:0] mem_addr_out, mem_wdata_out, mem_rdata_in, base, ip_now;
   int mismatches, checked;

   // strobes map onto the one-cycle inputs; the pin is active low
   assign management_interrupt_pin_n_in = ~strobes[7];
   assign {lic_msg_mgmt_in, lic_msg_valid_in, soft_init_in, halt_exec_in, resume_in, intr_in, seg_load_in}
      = strobes[6:0];

   mgmt_resume_control dut (.*);
   mgmt_ram_model ram (.mclk_in(mclk_in), .resetn_in(resetn_in), .req_in(mem_req_out), .we_in(mem_we_out),
      .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in), .ack_out(mem_ack_in));

   // ********************************************************************
   // tasks
   // ********************************************************************
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("Error: %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one-cycle strobe, core-side levels refreshed on the same edge
   task automatic pulse(input logic [7:0] m);
      @(posedge mclk_in);
      strobes <= m;
      instr_ip_in <= ip_now;
      next_ip_in <= ip_now + 32'h0000_0004;
      io_trap_in <= trap_now;
      halt_cached_in <= cached_now;
      seg_sel_in <= sel_now;
      @(posedge mclk_in);
      strobes <= 8'h00;
      #1;
   endtask

   // bounded wait for the one-cycle ip load, left in that cycle
   task automatic wait_load();
      int n;
      n = 0;
      do begin
         @(posedge mclk_in);
         #1;
         n++;
      end while (ip_load_out !== 1'b1 && n < 300);
      check("ip load", 1, ip_load_out);
   endtask

   task automatic enter(input logic [7:0] how, input logic was_halted);
      pulse(how);
      wait_load();
      check("entry ip", 32'h0000_8000, ip_value_out);
      check("code base", base, cs_base_out);
      check("cap id", {16'h0003, ARCH_VERSION}, ram.words[base + 32'h0000_7efc]);
      check("restart word", {15'h0, was_halted, 16'h0000}, ram.words[base + 32'h0000_7f00]);
   endtask

   // handler edits the save area, then resumes
   task automatic leave(input logic [31:0] word, input logic [31:0] nbase, input logic [31:0] ip, input logic rh);
      ram.words[base + 32'h0000_7f00] = word;
      ram.words[base + 32'h0000_7ef8] = nbase;
      pulse(P_RES);
      wait_load();
      check("return ip", ip, ip_value_out);
      check("reexec", word[7:0] == 8'hff, io_reexec_out);
      check("mode off", 0, management_mode_out);
      base = nbase;
      @(posedge mclk_in);
      #1;
      check("refetch", rh && !cached_now, halt_fetch_out);
      @(posedge mclk_in);
      #1;
      check("halt bus", rh, halt_bus_out);
      check("halted again", rh, halted_out);
      check("base", base, mgmt_ram_base_out);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ********************************************************************
   // clock, watchdog and sequence
   // ********************************************************************
   initial begin
      mclk_in = 1'b0;
      forever #25 mclk_in = ~mclk_in;
   end

   // the sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge mclk_in);
      mismatches++;
      final_report();
   end

   initial begin
      mismatches = 0;
      checked = 0;
      strobes = 8'h00;
      resetn_in = 1'b0;
      {instr_ip_in, next_ip_in, io_trap_in, halt_cached_in, seg_sel_in} = '0;
      {ip_now, trap_now, cached_now, sel_now} = '0;
      base = 32'h0003_0000;
      repeat (10) @(posedge mclk_in);
      resetn_in <= 1'b1;
      pulse(8'h00);
      check("reset base", 32'h0003_0000, mgmt_ram_base_out);
      // trapped i/o restarted, unaligned relocation; handler knows the cause itself
      ip_now = 32'h0000_0100;
      trap_now = 1'b1;
      enter(P_PIN, 1'b0);
      sel_now = 16'habcd;
      pulse(P_SEG);
      check("seg base", 32'h000a_bcd0, seg_base_out);
      leave(32'h0000_00ff, 32'h0001_2345, 32'h0000_0100, 1'b0);
      pulse(P_LICX);
      pulse(8'h00);
      check("no entry", 0, management_mode_out);
      // slow memory, relocated base, restart field left clear
      ram.delay = 3;
      ip_now = 32'h0000_0200;
      enter(P_LIC, 1'b0);
      leave(32'h0000_0000, base, 32'h0000_0204, 1'b0);
      ram.delay = 0;
      ip_now = 32'h0000_0300;
      trap_now = 1'b0;
      pulse(P_HALT);
      check("halted", 1, halted_out);
      pulse(P_SOFT);
      check("soft init base", base, mgmt_ram_base_out);
      // halt flag kept uncached, kept cached, cleared; set only after a halted entry
      for (int i = 0; i < 3; i++) begin
         cached_now = (i == 1);
         pulse(P_HALT);
         enter(P_PIN, 1'b1);
         leave({15'h0, i < 2, 16'h0000}, base, (i < 2) ? ip_now : ip_now + 32'h0000_0004, i < 2);
         pulse(P_INTR);
      end
      // halt inside the handler, soft init and resume tried before the interrupt wakes it; no second request meanwhile
      ip_now = 32'h0000_0400;
      trap_now = 1'b1;
      enter(P_PIN, 1'b0);
      pulse(P_HALT);
      pulse(P_SOFT | P_RES);
      check("halted in mode", 1, halted_out);
      pulse(P_INTR);
      check("woken", 0, halted_out);
      leave(32'h0000_0000, 32'h00ff_ffff, 32'h0000_0404, 1'b0);
      enter(P_LIC, 1'b0);
      // reset in mid-handler restores the default base
      resetn_in <= 1'b0;
      pulse(8'h00);
      resetn_in <= 1'b1;
      pulse(8'h00);
      check("base after reset", 32'h0003_0000, mgmt_ram_base_out);
      check("mode after reset", 0, management_mode_out);
      final_report();
   end
endmodule
